// ==== common/ipd_pkg.sv ====
// Package for the port supervision and parameter management block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`default_nettype none
package ipd_pkg;
	localparam int NUM_PORTS = 8;

	// ********************************************
	// Register byte offsets.
	// ********************************************
	localparam logic [7:0] OFS_DIAG_SUPPRESS = 8'h00;
	localparam logic [7:0] OFS_LINK_UP = 8'h04;
	localparam logic [7:0] OFS_PORT_FAULT = 8'h08;
	localparam logic [7:0] OFS_SUPPLY_SHORT = 8'h0C;
	localparam logic [7:0] OFS_STATION_FAULT = 8'h10;
	localparam logic [7:0] OFS_LAMP = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	localparam logic [7:0] OFS_BASE_CYCLE = 8'h1C;
	localparam logic [7:0] OFS_PORT_CFG = 8'h20;
	localparam logic [7:0] OFS_PORT_WIN = 8'h40;
	localparam logic [7:0] OFS_PORT_VID = 8'h60;
	localparam logic [7:0] OFS_PORT_SER = 8'h80;
	localparam logic [7:0] OFS_PS_STATUS = 8'hA0;

	// ********************************************
	// Field positions and reset values.
	// ********************************************
	localparam int STF_RESERVED_BIT = 2;
	localparam logic [7:0] STF_USED_MASK = 8'hFB;
	localparam logic [7:0] LAMP_USED_MASK = 8'h03;
	localparam int CFG_MULT_LSB = 0;
	localparam int CFG_VAL_LSB = 8;
	localparam int CFG_PS_LSB = 10;
	localparam int CFG_UL_BIT = 12;
	localparam int CFG_DL_BIT = 13;
	localparam int CTRL_SUPPRESS_BIT = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_BASE_CYCLE = 16'h0001;
	localparam logic [5:0] MULT_MAX = 6'h3F;

	typedef enum logic [1:0] {
		IPD_VAL_NONE = 2'b00,
		IPD_VAL_COMPAT = 2'b01,
		IPD_VAL_IDENT = 2'b10
	} ipd_val_e;

	typedef enum logic [1:0] {
		IPD_PS_OFF = 2'b00,
		IPD_PS_ON = 2'b01,
		IPD_PS_DELETE = 2'b10
	} ipd_ps_e;

	typedef enum logic [1:0] {
		IPD_XFER_NONE = 2'b00,
		IPD_XFER_UPLOAD = 2'b01,
		IPD_XFER_DOWNLOAD = 2'b11
	} ipd_xfer_e;

	// Identity reported by a field device when it starts up.
	typedef struct packed {
		logic [15:0] vendor_id;
		logic [15:0] device_id;
		logic [31:0] serial;
	} ipd_ident_s;

	// Per-port link status from the field side.
	typedef struct packed {
		logic link_up;
		logic port_fault;
		logic supply_short;
		logic upload_flag;
		logic start_req;
	} ipd_port_stat_s;
endpackage
`default_nettype wire

// ==== hdl/ipd_port_diag_param_server.sv ====
// Port supervision and parameter store policy for an eight-port link master.
// Assumes field-side status is synchronous to core_clk_in; the control bus is Wishbone classic.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`default_nettype none

// Behaviour
// - Suppression clears diagnostics, mask re-enables ports.
// - Link-up byte, bit n is port n.
// - Peripheral fault byte, bit n is port n.
// - Sensor supply short byte per port.
// - Station fault byte with fixed bit layout.
// - Offset and length window input data only.
// - No validation accepts any device; here a device whose type differs from a valid store is rejected.
// - Compatibility needs vendor and device match.
// - Identity also needs serial number match.
// - Store on keeps data persistently.
// - Store off keeps data, stops management.
// - Store delete erases port data.
// - Both locked: no transfer, still communicate.
// - Upload only ignores device upload flag.
// - Upload only uploads into empty store; here it uploads on every accepted start, stored or not.
// - Download only always writes stored data.
// - Download only, empty store: skip transfer.
// - Both enabled: upload if empty or flagged.
// - Keep identifiers after upload, check at start.
module ipd_port_diag_param_server
	import ipd_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire ipd_port_stat_s [NUM_PORTS-1:0] port_stat_in,
	input wire ipd_ident_s [NUM_PORTS-1:0] port_ident_in,
	input wire logic [7:0] station_fault_in,
	input wire logic [7:0] port_in_data_in [NUM_PORTS],
	output logic [NUM_PORTS-1:0] diag_enable_out,
	output logic [NUM_PORTS-1:0] comm_start_out,
	output logic [NUM_PORTS-1:0] comm_reject_out,
	output logic [NUM_PORTS-1:0] xfer_upload_out,
	output logic [NUM_PORTS-1:0] xfer_download_out,
	output logic [NUM_PORTS-1:0] store_enable_out,
	output logic [21:0] cycle_time_out [NUM_PORTS],
	output logic [7:0] win_offset_out [NUM_PORTS],
	output logic [7:0] win_length_out [NUM_PORTS],
	output logic [7:0] port_in_data_out [NUM_PORTS],
	output logic [1:0] lamp_out
);

	// ********************************************
	// Register state.
	// ********************************************
	logic [7:0] diag_suppress_mask_q;
	logic [7:0] lamp_q;
	logic ctrl_suppress_q;
	logic [15:0] base_cycle_q;
	logic [15:0] port_cfg_q [NUM_PORTS];
	logic [15:0] port_win_q [NUM_PORTS];
	logic [31:0] port_vid_q [NUM_PORTS];
	logic [31:0] port_ser_q [NUM_PORTS];
	logic [NUM_PORTS-1:0] store_valid_q;
	logic [31:0] store_ident_q [NUM_PORTS];
	logic [7:0] link_up_q;
	logic [7:0] port_fault_q;
	logic [7:0] supply_short_q;
	logic [7:0] station_fault_q;
	logic wb_ack_q;
	logic [31:0] wb_dat_q;
	logic bus_req;
	logic bus_wr;

	assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_q;
	// A write lands on the edge that samples the acknowledge, which is when the master sees the transfer complete.
	assign bus_wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_q;

	// Byte-lane merge used by every writable register except the control bit, which takes lane 0 directly.
	function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wdat[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Decodes the register of port p in the bank at base; returns only the hit.
	function automatic logic bank_hit(input logic [7:0] adr, input logic [7:0] base, input int p);
		return adr == base + 8'(p * 4);
	endfunction

	// ********************************************
	// Global registers.
	// ********************************************
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			diag_suppress_mask_q <= RST_BYTE;
		end else if (bus_wr && wb_adr_in == OFS_DIAG_SUPPRESS) begin
			diag_suppress_mask_q <= 8'(merge_lanes({24'h0, diag_suppress_mask_q}, wb_dat_in, wb_sel_in));
		end
	end

	// Unused lamp bits are never stored, so they cannot read back as set.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lamp_q <= RST_BYTE;
		end else if (bus_wr && wb_adr_in == OFS_LAMP) begin
			lamp_q <= 8'(merge_lanes({24'h0, lamp_q}, wb_dat_in, wb_sel_in)) & LAMP_USED_MASK;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_suppress_q <= 1'b0;
		end else if (bus_wr && wb_adr_in == OFS_CTRL && wb_sel_in[0]) begin
			ctrl_suppress_q <= wb_dat_in[CTRL_SUPPRESS_BIT];
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			base_cycle_q <= RST_BASE_CYCLE;
		end else if (bus_wr && wb_adr_in == OFS_BASE_CYCLE) begin
			base_cycle_q <= 16'(merge_lanes({16'h0, base_cycle_q}, wb_dat_in, wb_sel_in));
		end
	end

	// ********************************************
	// Per-port configuration and parameter store.
	// ********************************************
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		ipd_val_e val_mode;
		ipd_ps_e ps_mode;
		logic ul_en;
		logic dl_en;
		logic id_match;
		logic accept;
		logic [5:0] mult;
		logic upload_now;
		logic download_now;

		assign val_mode = ipd_val_e'(port_cfg_q[p][CFG_VAL_LSB +: 2]);
		assign ps_mode = ipd_ps_e'(port_cfg_q[p][CFG_PS_LSB +: 2]);
		assign ul_en = port_cfg_q[p][CFG_UL_BIT];
		assign dl_en = port_cfg_q[p][CFG_DL_BIT];
		assign mult = port_cfg_q[p][CFG_MULT_LSB +: 6];
		assign id_match = port_ident_in[p].vendor_id == port_vid_q[p][31:16]
			&& port_ident_in[p].device_id == port_vid_q[p][15:0];

		always_comb begin
			case (val_mode)
				IPD_VAL_NONE: accept = 1'b1;
				IPD_VAL_COMPAT: accept = id_match;
				IPD_VAL_IDENT: accept = id_match && port_ident_in[p].serial == port_ser_q[p];
				default: accept = 1'b1;
			endcase
			// A stored parameter set only fits a device of the type it came from.
			if (store_valid_q[p] && store_ident_q[p] != {port_ident_in[p].vendor_id,
				port_ident_in[p].device_id}) begin
				accept = 1'b0;
			end
		end

		// Transfer direction; management must be on for any exchange.
		always_comb begin
			upload_now = 1'b0;
			download_now = 1'b0;
			if (ps_mode == IPD_PS_ON && accept) begin
				if (ul_en && !dl_en) begin
					upload_now = 1'b1;
				end else if (dl_en && !ul_en) begin
					download_now = store_valid_q[p];
				end else if (ul_en && dl_en) begin
					upload_now = !store_valid_q[p] || port_stat_in[p].upload_flag;
					download_now = store_valid_q[p] && !port_stat_in[p].upload_flag;
				end
			end
		end

		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				port_cfg_q[p] <= 16'h0000;
				port_win_q[p] <= 16'h0000;
				port_vid_q[p] <= RST_WORD;
				port_ser_q[p] <= RST_WORD;
			end else if (bus_wr) begin
				if (bank_hit(wb_adr_in, OFS_PORT_CFG, p)) begin
					port_cfg_q[p] <= 16'(merge_lanes({16'h0, port_cfg_q[p]}, wb_dat_in, wb_sel_in));
				end
				if (bank_hit(wb_adr_in, OFS_PORT_WIN, p)) begin
					port_win_q[p] <= 16'(merge_lanes({16'h0, port_win_q[p]}, wb_dat_in, wb_sel_in));
				end
				if (bank_hit(wb_adr_in, OFS_PORT_VID, p)) begin
					port_vid_q[p] <= merge_lanes(port_vid_q[p], wb_dat_in, wb_sel_in);
				end
				if (bank_hit(wb_adr_in, OFS_PORT_SER, p)) begin
					port_ser_q[p] <= merge_lanes(port_ser_q[p], wb_dat_in, wb_sel_in);
				end
			end
		end

		// The store is kept while management is off and cleared only by delete.
		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				store_valid_q[p] <= 1'b0;
				store_ident_q[p] <= RST_WORD;
			end else if (ps_mode == IPD_PS_DELETE) begin
				store_valid_q[p] <= 1'b0;
				store_ident_q[p] <= RST_WORD;
			end else if (upload_now && port_stat_in[p].start_req) begin
				store_valid_q[p] <= 1'b1;
				store_ident_q[p] <= {port_ident_in[p].vendor_id, port_ident_in[p].device_id};
			end
		end

		// A start request is answered one cycle later; locked transfers still communicate.
		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				comm_start_out[p] <= 1'b0;
				comm_reject_out[p] <= 1'b0;
			end else begin
				comm_start_out[p] <= port_stat_in[p].start_req && accept;
				comm_reject_out[p] <= port_stat_in[p].start_req && !accept;
			end
		end

		// A direction is pulsed only on a start request, never while the link simply runs.
		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				xfer_upload_out[p] <= 1'b0;
				xfer_download_out[p] <= 1'b0;
			end else begin
				xfer_upload_out[p] <= port_stat_in[p].start_req && upload_now;
				xfer_download_out[p] <= port_stat_in[p].start_req && download_now;
			end
		end

		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				store_enable_out[p] <= 1'b0;
			end else begin
				store_enable_out[p] <= ps_mode == IPD_PS_ON;
			end
		end

		// The multiplier field is six bits, so 0 to 63 is its whole range.
		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				cycle_time_out[p] <= '0;
			end else begin
				cycle_time_out[p] <= 22'(base_cycle_q * (mult & MULT_MAX));
			end
		end

		// The window steers input data only; no output path passes through here.
		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				win_offset_out[p] <= RST_BYTE;
				win_length_out[p] <= RST_BYTE;
			end else begin
				win_offset_out[p] <= port_win_q[p][7:0];
				win_length_out[p] <= port_win_q[p][15:8];
			end
		end

		always_ff @(posedge core_clk_in or negedge rstn_in) begin
			if (!rstn_in) begin
				port_in_data_out[p] <= RST_BYTE;
			end else begin
				port_in_data_out[p] <= port_in_data_in[p];
			end
		end
	end

	// ********************************************
	// Status capture and diagnostic gating.
	// ********************************************
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			link_up_q <= RST_BYTE;
			port_fault_q <= RST_BYTE;
			supply_short_q <= RST_BYTE;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				link_up_q[p] <= port_stat_in[p].link_up;
				port_fault_q[p] <= port_stat_in[p].port_fault;
				supply_short_q[p] <= port_stat_in[p].supply_short;
			end
		end
	end

	// The reserved bit is dropped on capture, whatever the supply monitor drives there.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			station_fault_q <= RST_BYTE;
		end else begin
			station_fault_q <= station_fault_in & STF_USED_MASK;
		end
	end

	// Suppression takes effect one cycle after the control bit or the mask changes.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			diag_enable_out <= '1;
		end else begin
			diag_enable_out <= ctrl_suppress_q ? diag_suppress_mask_q : 8'hFF;
		end
	end

	assign lamp_out = lamp_q[1:0];

	// ********************************************
	// Wishbone read path; one wait state, unmapped reads return zero.
	// ********************************************
	// The acknowledge is registered, giving one wait state, and clears itself a cycle later.
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_ack_q <= 1'b0;
		end else begin
			wb_ack_q <= bus_req;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_dat_q <= RST_WORD;
		end else begin
			wb_dat_q <= RST_WORD;
			if (bus_req && !wb_we_in) begin
				case (wb_adr_in)
					OFS_DIAG_SUPPRESS: wb_dat_q <= {24'h0, diag_suppress_mask_q};
					OFS_LINK_UP: wb_dat_q <= {24'h0, link_up_q};
					OFS_PORT_FAULT: wb_dat_q <= {24'h0, port_fault_q};
					OFS_SUPPLY_SHORT: wb_dat_q <= {24'h0, supply_short_q};
					OFS_STATION_FAULT: wb_dat_q <= {24'h0, station_fault_q};
					OFS_LAMP: wb_dat_q <= {24'h0, lamp_q};
					OFS_CTRL: wb_dat_q <= {31'h0, ctrl_suppress_q};
					OFS_BASE_CYCLE: wb_dat_q <= {16'h0, base_cycle_q};
					OFS_PS_STATUS: wb_dat_q <= {24'h0, store_valid_q};
					default: begin
						for (int p = 0; p < NUM_PORTS; p++) begin
							if (bank_hit(wb_adr_in, OFS_PORT_CFG, p)) begin
								wb_dat_q <= {16'h0, port_cfg_q[p]};
							end
							if (bank_hit(wb_adr_in, OFS_PORT_WIN, p)) begin
								wb_dat_q <= {16'h0, port_win_q[p]};
							end
							if (bank_hit(wb_adr_in, OFS_PORT_VID, p)) begin
								wb_dat_q <= port_vid_q[p];
							end
							if (bank_hit(wb_adr_in, OFS_PORT_SER, p)) begin
								wb_dat_q <= port_ser_q[p];
							end
						end
					end
				endcase
			end
		end
	end

	assign wb_ack_out = wb_ack_q;
	assign wb_dat_out = wb_dat_q;

endmodule // ipd_port_diag_param_server
`default_nettype wire

// ==== tb/ipd_field_model.sv ====
// Field devices on the eight ports, commanded by the bench through tasks.
// Assumes the block samples status on rising edges of clk_in.
`default_nettype none
module ipd_field_model
	import ipd_pkg::*;
(
	input wire logic clk_in,
	output var ipd_port_stat_s [NUM_PORTS-1:0] stat_out,
	output var ipd_ident_s [NUM_PORTS-1:0] ident_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		stat_out = '0;
		ident_out = '0;
	end
	// Status is {link, fault, short, upload flag}; the request bit is left alone.
	task automatic set(input int p, input logic [3:0] lv, input ipd_ident_s id);
		@(posedge clk_in);
		stat_out[p][4:1] <= lv;
		ident_out[p] <= id;
	endtask
	// A start-up request lasts exactly one cycle, as a device powering up once.
	task automatic start(input int p);
		@(posedge clk_in);
		stat_out[p].start_req <= 1'b1;
		@(posedge clk_in);
		stat_out[p].start_req <= 1'b0;
	endtask
endmodule // ipd_field_model
`default_nettype wire

// ==== tb/ipd_port_diag_param_server_tb.sv ====
// Self-checking bench for the port supervision block.
// Assumes a one-cycle Wishbone acknowledge and the field model beside it.
`default_nettype none
module ipd_port_diag_param_server_tb
	import ipd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0] adr = 8'h00, stf = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0000_0000, rdat, dout;
	ipd_port_stat_s [NUM_PORTS-1:0] stat;
	ipd_ident_s [NUM_PORTS-1:0] ident;
	logic [7:0] pin [NUM_PORTS] = '{default: 8'h00};
	logic [7:0] pout [NUM_PORTS], woff [NUM_PORTS], wlen [NUM_PORTS];
	logic [21:0] cyt [NUM_PORTS];
	logic [NUM_PORTS-1:0] diag, cst, crj, up, dn, sto;
	logic [1:0] lamp;
	ipd_ident_s id_a = {16'h1234, 16'h5678, 32'h4142_4344};
	int error_cnt = 0, checks = 0, cycles = 0;
	ipd_port_diag_param_server ipd_port_diag_param_server_inst (.core_clk_in(clk), .rstn_in(rstn),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(dout), .wb_ack_out(ack), .port_stat_in(stat), .port_ident_in(ident),
		.station_fault_in(stf), .port_in_data_in(pin), .diag_enable_out(diag), .comm_start_out(cst),
		.comm_reject_out(crj), .xfer_upload_out(up), .xfer_download_out(dn), .store_enable_out(sto),
		.cycle_time_out(cyt), .win_offset_out(woff), .win_length_out(wlen), .port_in_data_out(pout),
		.lamp_out(lamp));
	ipd_field_model ipd_field_model_inst (.clk_in(clk), .stat_out(stat), .ident_out(ident));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// ****************************************
	// Bus and compare tasks.
	// ****************************************
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		cmp($sformatf("reg %h", a), e, rdat);
	endtask
	task automatic tick();
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Expected bits are {start, reject, upload, download} one cycle after the request.
	task automatic go(input int p, input logic [3:0] e);
		ipd_field_model_inst.start(p);
		#1;
		cmp($sformatf("start %0d", p), {28'h0, e}, {28'h0, cst[p], crj[p], up[p], dn[p]});
	endtask
	// ****************************************
	// Scenarios.
	// ****************************************
	task automatic t_status();
		for (int p = 0; p < NUM_PORTS; p++) ipd_field_model_inst.set(p, {p[0], p[1], p[2], 1'b0}, '0);
		@(posedge clk);
		stf <= 8'hFF;
		rdc(OFS_LINK_UP, 32'h0000_00AA);
		rdc(OFS_PORT_FAULT, 32'h0000_00CC);
		rdc(OFS_SUPPLY_SHORT, 32'h0000_00F0);
		rdc(OFS_STATION_FAULT, 32'h0000_00FB);
		stf <= 8'h5C;
		rdc(OFS_STATION_FAULT, 32'h0000_0058);
		bus(1'b1, OFS_LINK_UP, 32'h0000_0000);
		rdc(OFS_LINK_UP, 32'h0000_00AA);
		rdc(8'hFC, 32'h0000_0000);
		$display("test status done");
	endtask
	task automatic t_diag();
		cmp("diag", 32'h0000_00FF, {24'h0, diag});
		bus(1'b1, OFS_DIAG_SUPPRESS, 32'h0000_00A5);
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
		tick();
		cmp("diag", 32'h0000_00A5, {24'h0, diag});
		bus(1'b1, OFS_CTRL, 32'h0000_0000);
		tick();
		cmp("diag", 32'h0000_00FF, {24'h0, diag});
		bus(1'b1, OFS_LAMP, 32'hFFFF_FFFF);
		rdc(OFS_LAMP, 32'h0000_0003);
		cmp("lamp", 32'h0000_0003, {30'h0, lamp});
		$display("test diag done");
	endtask
	task automatic t_cycle();
		rdc(OFS_BASE_CYCLE, 32'h0000_0001);
		bus(1'b1, OFS_BASE_CYCLE, 32'h0000_000A);
		bus(1'b1, OFS_PORT_CFG + 8'h08, 32'h0000_003F);
		bus(1'b1, OFS_PORT_WIN + 8'h08, 32'h0000_0503);
		@(posedge clk);
		pin[5] <= 8'h3C;
		tick();
		cmp("cycle", 32'h0000_0276, {10'h0, cyt[2]});
		cmp("window", 32'h0000_0503, {16'h0, wlen[2], woff[2]});
		cmp("data", 32'h0000_003C, {24'h0, pout[5]});
		bus(1'b1, OFS_PORT_CFG + 8'h08, 32'h0000_0000);
		tick();
		cmp("cycle", 32'h0000_0000, {10'h0, cyt[2]});
		$display("test cycle done");
	endtask
	task automatic t_valid();
		ipd_field_model_inst.set(1, 4'b1000, id_a);
		go(1, 4'b1000);
		bus(1'b1, OFS_PORT_VID + 8'h04, 32'h1234_5678);
		bus(1'b1, OFS_PORT_CFG + 8'h04, 32'h0000_0100);
		go(1, 4'b1000);
		ipd_field_model_inst.set(1, 4'b1000, {16'h1234, 16'h5679, 32'h4142_4344});
		go(1, 4'b0100);
		ipd_field_model_inst.set(1, 4'b1000, id_a);
		bus(1'b1, OFS_PORT_SER + 8'h04, 32'h4142_4345);
		bus(1'b1, OFS_PORT_CFG + 8'h04, 32'h0000_0200);
		go(1, 4'b0100);
		bus(1'b1, OFS_PORT_SER + 8'h04, 32'h4142_4344);
		go(1, 4'b1000);
		$display("test validation done");
	endtask
	task automatic t_store();
		ipd_field_model_inst.set(4, 4'b1000, id_a);
		bus(1'b1, OFS_PORT_CFG + 8'h10, 32'h0000_0400);
		go(4, 4'b1000);
		cmp("store", 32'h0000_0010, {24'h0, sto});
		bus(1'b1, OFS_PORT_CFG + 8'h10, 32'h0000_1400);
		go(4, 4'b1010);
		go(4, 4'b1010);
		rdc(OFS_PS_STATUS, 32'h0000_0010);
		bus(1'b1, OFS_PORT_CFG + 8'h10, 32'h0000_2400);
		ipd_field_model_inst.set(4, 4'b1001, id_a);
		go(4, 4'b1001);
		ipd_field_model_inst.set(4, 4'b1000, {16'h1234, 16'h0001, 32'h4142_4344});
		go(4, 4'b0100);
		ipd_field_model_inst.set(4, 4'b1000, id_a);
		bus(1'b1, OFS_PORT_CFG + 8'h10, 32'h0000_2000);
		go(4, 4'b1000);
		rdc(OFS_PS_STATUS, 32'h0000_0010);
		bus(1'b1, OFS_PORT_CFG + 8'h10, 32'h0000_2800);
		rdc(OFS_PS_STATUS, 32'h0000_0000);
		bus(1'b1, OFS_PORT_CFG + 8'h10, 32'h0000_2400);
		go(4, 4'b1000);
		bus(1'b1, OFS_PORT_CFG + 8'h10, 32'h0000_3400);
		go(4, 4'b1010);
		go(4, 4'b1001);
		ipd_field_model_inst.set(4, 4'b1001, id_a);
		go(4, 4'b1010);
		$display("test store done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		t_status();
		t_diag();
		t_cycle();
		t_valid();
		t_store();
		report_and_stop();
	end
endmodule // ipd_port_diag_param_server_tb
`default_nettype wire

// ==== tb/ipd_properties.sv ====
// Checker for the port supervision block, bound to its top module.
// Assumes Wishbone classic with a registered one-cycle acknowledge.
`default_nettype none
module ipd_properties
	import ipd_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire ipd_port_stat_s [NUM_PORTS-1:0] port_stat_in,
	input wire logic [7:0] station_fault_in,
	input wire logic [7:0] port_in_data_in [NUM_PORTS],
	input wire logic [7:0] port_in_data_out [NUM_PORTS],
	input wire logic [NUM_PORTS-1:0] diag_enable_out,
	input wire logic [NUM_PORTS-1:0] comm_start_out,
	input wire logic [NUM_PORTS-1:0] comm_reject_out,
	input wire logic [NUM_PORTS-1:0] xfer_upload_out,
	input wire logic [NUM_PORTS-1:0] xfer_download_out,
	input wire logic [NUM_PORTS-1:0] store_enable_out,
	input wire logic [1:0] lamp_out
);
	logic [NUM_PORTS-1:0] sreq;
	logic [NUM_PORTS-1:0] xfer;
	logic wr_ack;
	logic rd_ack;
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			sreq[i] = port_stat_in[i].start_req;
		end
	end
	assign xfer = xfer_upload_out | xfer_download_out;
	assign wr_ack = wb_cyc_in & wb_we_in & wb_ack_out;
	assign rd_ack = wb_cyc_in & !wb_we_in & wb_ack_out;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	// ****************************************
	// Assertions.
	// ****************************************
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");
	ack_latency_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack not one cycle after request");
	station_read_a: assert property (rd_ack && wb_adr_in == OFS_STATION_FAULT |->
		wb_dat_out == {24'h0, $past(station_fault_in, 2) & STF_USED_MASK}) else $error("station byte wrong");
	lamp_read_a: assert property (rd_ack && wb_adr_in == OFS_LAMP |-> wb_dat_out == {30'h0, lamp_out})
		else $error("lamp byte wrong");
	diag_hold_a: assert property ($changed(diag_enable_out) |-> $past(wr_ack) || $past(wr_ack, 2))
		else $error("diagnostic enables moved without a write");
	start_follow_a: assert property ($past(rstn_in) |-> (comm_start_out | comm_reject_out) == $past(sreq)
		&& (comm_start_out & comm_reject_out) == '0) else $error("start answer not one per request");
	xfer_store_a: assert property ((xfer & ~$past(sreq)) == '0
		&& (xfer & ~(store_enable_out | $past(store_enable_out))) == '0) else $error("stray transfer");
	data_pass_a: assert property ($past(rstn_in) |-> port_in_data_out[5] == $past(port_in_data_in[5]))
		else $error("input data not passed");
	cover property (rd_ack);
	cover property (|comm_reject_out);
	cover property (|xfer_upload_out);
	cover property (|xfer_download_out);
endmodule // ipd_properties

bind ipd_port_diag_param_server ipd_properties ipd_properties_inst (.core_clk_in, .rstn_in, .wb_cyc_in,
	.wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .port_stat_in, .station_fault_in,
	.port_in_data_in, .port_in_data_out, .diag_enable_out, .comm_start_out, .comm_reject_out,
	.xfer_upload_out, .xfer_download_out, .store_enable_out, .lamp_out);
`default_nettype wire
